// File: rtl/scs_pkg.sv
// shared constants and types of the serializer control/status registers
`default_nettype none

package scs_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOW      = 8'h19;
  localparam logic [7:0] IDX_PATH     = 8'h1a;
  localparam logic [7:0] IDX_ERR      = 8'h1b;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h21;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h22;
  localparam int unsigned AW          = 10;

  // reset values
  localparam logic [7:0] LOW_RST  = 8'h7f;
  localparam logic [7:0] PATH_RST = 8'h01;
  localparam logic [7:0] ERR_RST  = 8'h00;

  // data path control field positions
  localparam int unsigned PATH_SURR_BIT = 0;
  localparam int unsigned PATH_WIDE_BIT = 1;
  localparam int unsigned PATH_AUX_BIT  = 3;

  // low period timing: one step per oscillator period, plus five
  localparam logic [8:0] LOW_EXTRA    = 9'h005;
  localparam real        OSC_NOM_NS   = 40.0;
  localparam real        STEP_MIN_NS  = 38.0952;
  localparam real        LOW_MIN_NS   = 5000.0;
  localparam real        REF_CLK_NS   = 100.0;
  // one step per ref_clk cycle: the oscillator period rounds up to one
  localparam int unsigned STEP_CYC =
    (OSC_NOM_NS <= REF_CLK_NS) ? 1 : int'($ceil(OSC_NOM_NS / REF_CLK_NS));

  // saturating counter top
  localparam logic [7:0] ERR_SAT = 8'hff;

  // interrupt status bits
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned IRQ_CRC0     = 0;
  localparam int unsigned IRQ_CRC1     = 1;
  localparam int unsigned IRQ_SAT      = 2;
  localparam int unsigned IRQ_LOW_DONE = 3;

  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // crc error strobes of both back channel ports
  typedef struct packed {
    logic port1;
    logic port0;
  } scs_crc_ev_t;

  // data path settings handed to the serializer core
  typedef struct packed {
    logic       wide_payload_select;
    logic       surround_active;
    logic       aux_audio_enable;
    logic [1:0] i2s_chan_cfg;
  } scs_path_cfg_t;

  // low period timer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_LOW  = 2'h2
  } scs_tmr_st_t;

endpackage

`default_nettype wire

// File: rtl/scs_low_timer.sv
// low period / setup interval timer in oscillator steps
`default_nettype none

module scs_low_timer
  import scs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] low_field,
  output logic            busy,
  output logic            done
);

  scs_tmr_st_t st_q;
  logic [8:0]  cnt_q;
  logic [8:0]  len_q;
  logic [8:0]  want_q;

  //////////////////////////////////////////////////////////////////////////
  // field is latched at start so a mid-period write cannot shorten it
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q  <= ST_IDLE;
      cnt_q <= 9'h000;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q  <= ST_LOW;
            cnt_q <= {1'b0, low_field} + LOW_EXTRA - 9'h001;
          end
        end
        ST_LOW: begin
          if (cnt_q == 9'h000) begin
            st_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign busy = (st_q == ST_LOW);
  assign done = busy && (cnt_q == 9'h000);

  // helper: measured busy length and expected length
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      len_q  <= 9'h000;
      want_q <= 9'h000;
    end else if (!busy && start) begin
      len_q  <= 9'h001;
      want_q <= {1'b0, low_field} + LOW_EXTRA;
    end else if (busy) begin
      len_q <= len_q + 9'h001;
    end
  end

  low_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done |-> len_q == want_q)
    else $error("low period length differs from field plus five");

  low_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!busy && start) |=> busy)
    else $error("timer did not start");

endmodule

`default_nettype wire

// File: rtl/scs_sat_counter.sv
// eight bit saturating error counter with clear
`default_nettype none

module scs_sat_counter
  import scs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       count_en,
  output logic [7:0]      count_q
);

  //////////////////////////////////////////////////////////////////////////
  // clear beats a same-cycle error: the new run starts from zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_q <= ERR_RST;
    end else if (clear) begin
      count_q <= ERR_RST;
    end else if (count_en && count_q != ERR_SAT) begin
      count_q <= count_q + 8'h01;
    end
  end

  sat_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count_q == ERR_SAT && !clear) |=> count_q == ERR_SAT)
    else $error("error counter wrapped past saturation");

  cnt_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear |=> count_q == 8'h00)
    else $error("error counter not cleared");

endmodule

`default_nettype wire

// File: rtl/scs_regs.sv
// serializer control/status register bank on ahb-lite
// Overview of operation
// - as local bus master, scl is held low for the low-time field; reset 0x7f
// - slave side reuses the same value as data setup before releasing scl
// - low period is field plus five oscillator steps of nominal 40 ns
// - default value gives at least 5 us even at a fast oscillator
// - data path bit 3 reads back the auxiliary audio enable
// - auxiliary audio enable is captured from mode strap zero at power-up
// - bit 1 picks 24-bit plus three controls, or 28-bit payload
// - bit 0 picks stereo/quad i2s audio, or 5.1/7.1 channel transport
// - surround audio only travels by the data island i2s method
// - in a repeater, in-band i2s mode detection overrides the surround bit
// - self-test back channel crc errors count in saturating 8-bit counter
// - counter clears on a new self-test run or the external clear bit
// - second port select makes counter reads show the second port
//
// Decided for this implementation: register access over AHB-Lite.
`default_nettype none

module scs_regs
  import scs_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // ahb-lite slave
  input  wire logic          hsel,
  input  wire logic [AW-1:0] haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // strap and bridge configuration mirror
  input  wire logic          mode_strap_pin_zero,
  input  wire logic          aux_audio_wr,
  input  wire logic          aux_audio_wr_val,
  // two-wire bus timing requests
  input  wire logic          master_low_start,
  input  wire logic          slave_setup_start,
  output logic               scl_drive_low,
  output logic               slave_setup_busy,
  output logic               slave_setup_done,
  // audio and payload configuration
  input  wire logic [1:0]    i2s_chan_cfg,
  input  wire logic          data_island_mode,
  input  wire logic          repeater_mode,
  input  wire logic          inband_i2s_valid,
  input  wire logic          inband_i2s_surround,
  output scs_path_cfg_t      path_cfg,
  // self-test back channel
  input  wire logic          bist_active,
  input  wire logic          bist_start,
  input  wire logic          err_count_clear,
  input  wire scs_crc_ev_t   crc_err,
  input  wire logic          second_port_select,
  // interrupt
  output logic               irq
);

  //////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]       low_q;
  logic [7:0]       path_q;
  logic             aux_q;
  logic             strap_done_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic             wr_q;
  logic [7:0]       widx_q;
  logic [31:0]      rdata_q;
  logic             addr_ok;
  logic [7:0]       err0;
  logic [7:0]       err1;
  logic             err_clear;
  logic             master_done;
  logic             surround_eff;
  logic [31:0]      rd_mux;

  // register index from a byte address; low two bits are ignored
  function automatic logic [7:0] idx_of(input logic [AW-1:0] a);
    idx_of = a[AW-1:2];
  endfunction

  // data path read view: reserved bits forced to zero
  function automatic logic [7:0] path_view(input logic [7:0] p,
                                           input logic       aux);
    path_view = 8'h00;
    path_view[PATH_SURR_BIT] = p[PATH_SURR_BIT];
    path_view[PATH_WIDE_BIT] = p[PATH_WIDE_BIT];
    path_view[PATH_AUX_BIT]  = aux;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: never stalls, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  // only word transfers of active type are taken
  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  // address phase capture of a write; data lands in the next cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q   <= 1'b0;
      widx_q <= 8'h00;
    end else if (hready) begin
      wr_q   <= addr_ok && hwrite;
      widx_q <= idx_of(haddr);
    end
  end

  // read mux, evaluated in the address phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx_of(haddr))
      IDX_LOW:      rd_mux[7:0] = low_q;
      IDX_PATH:     rd_mux[7:0] = path_view(path_q, aux_q);
      IDX_ERR:      rd_mux[7:0] = second_port_select ? err1 : err0;
      IDX_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      IDX_IRQ_EN:   rd_mux[IRQ_W-1:0] = irq_en_q;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered so it stands through the data phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // low-time register, shared by master low and slave setup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      low_q <= LOW_RST;
    end else if (wr_q && widx_q == IDX_LOW) begin
      low_q <= hwdata[7:0];
    end
  end

  // data path control; only the two writable bits are stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      path_q <= PATH_RST;
    end else if (wr_q && widx_q == IDX_PATH) begin
      path_q <= 8'h00;
      path_q[PATH_WIDE_BIT] <= hwdata[PATH_WIDE_BIT];
      path_q[PATH_SURR_BIT] <= hwdata[PATH_SURR_BIT];
    end
  end

  // aux audio copy: strap caught in the first cycle after reset release,
  // later follows writes to the bridge configuration register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_q        <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      aux_q        <= mode_strap_pin_zero;
      strap_done_q <= 1'b1;
    end else if (aux_audio_wr) begin
      aux_q <= aux_audio_wr_val;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // audio and payload settings
  // repeater: detected in-band mode wins over software
  assign surround_eff = (repeater_mode && inband_i2s_valid) ?
                        inband_i2s_surround :
                        path_q[PATH_SURR_BIT];

  // surround is withheld unless the data island method is in use
  assign path_cfg.surround_active = surround_eff && data_island_mode;
  assign path_cfg.wide_payload_select = path_q[PATH_WIDE_BIT];
  assign path_cfg.aux_audio_enable    = aux_q;
  // stereo/quad setting applies only while surround is off
  assign path_cfg.i2s_chan_cfg =
    path_cfg.surround_active ? 2'h0 : i2s_chan_cfg;

  //////////////////////////////////////////////////////////////////////////
  // master scl low period
  scs_low_timer u_master_low (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (master_low_start),
    .low_field (low_q),
    .busy      (scl_drive_low),
    .done      (master_done)
  );

  // slave data setup before scl release reuses the same field
  scs_low_timer u_slave_setup (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (slave_setup_start),
    .low_field (low_q),
    .busy      (slave_setup_busy),
    .done      (slave_setup_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // back channel error counters, one per port
  assign err_clear = bist_start || err_count_clear;

  scs_sat_counter u_err0 (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clear    (err_clear),
    .count_en (bist_active && crc_err.port0),
    .count_q  (err0)
  );

  scs_sat_counter u_err1 (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clear    (err_clear),
    .count_en (bist_active && crc_err.port1),
    .count_q  (err1)
  );

  //////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one-to-clear, enable mask
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CRC0] = bist_active && crc_err.port0;
    irq_set[IRQ_CRC1] = bist_active && crc_err.port1;
    irq_set[IRQ_SAT]  = (err0 == ERR_SAT) || (err1 == ERR_SAT);
    irq_set[IRQ_LOW_DONE] = master_done;
  end

  assign irq_clr = (wr_q && widx_q == IDX_IRQ_CLR) ?
                   hwdata[IRQ_W-1:0] : '0;

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_en_q <= '0;
    end else if (wr_q && widx_q == IDX_IRQ_EN) begin
      irq_en_q <= hwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  //////////////////////////////////////////////////////////////////////////
  // checks
  default_low_a: assert property (@(posedge ref_clk)
    (real'(LOW_RST) + real'(LOW_EXTRA)) * STEP_MIN_NS >= LOW_MIN_NS)
    else $error("default low period below minimum");

  low_reset_a: assert property (@(posedge ref_clk)
    !rst_n |=> low_q == LOW_RST)
    else $error("low-time register reset value wrong");

  strap_cap_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !strap_done_q |=> aux_q == $past(mode_strap_pin_zero))
    else $error("strap not captured into aux audio enable");

  path_rsv_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (path_q & 8'hfc) == 8'h00)
    else $error("reserved data path bits stored");

  surr_dim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !data_island_mode |-> !path_cfg.surround_active)
    else $error("surround active without data island transport");

  rpt_over_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (repeater_mode && inband_i2s_valid && data_island_mode)
      |-> path_cfg.surround_active == inband_i2s_surround)
    else $error("in-band surround mode did not override");

  err_view_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (addr_ok && !hwrite && idx_of(haddr) == IDX_ERR)
      |=> hrdata[7:0] == ($past(second_port_select) ?
                          $past(err1) : $past(err0)))
    else $error("error count read shows wrong port");

  wide_fol_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_q && widx_q == IDX_PATH)
      |=> path_cfg.wide_payload_select == $past(hwdata[PATH_WIDE_BIT]))
    else $error("payload format did not follow write");

  setup_eq_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (master_low_start && slave_setup_start && !scl_drive_low &&
     !slave_setup_busy) |=> ##[1:300] (master_done && slave_setup_done))
    else $error("setup interval differs from low period");

  irq_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq_set[IRQ_CRC0] |=> irq_stat_q[IRQ_CRC0])
    else $error("crc event lost from status");

  low_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    master_done);
  sat_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    err0 == ERR_SAT);
  port1_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    second_port_select && addr_ok && idx_of(haddr) == IDX_ERR);

endmodule

`default_nettype wire

// File: tb/scs_regs_bench.sv
// self-checking bench of the serializer control/status register bank
`default_nettype none

module scs_regs_bench
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic          ref_clk, rst_n, hsel, hwrite, hready, hresp;
  logic [AW-1:0] haddr;
  logic [1:0]    htrans, i2s_chan_cfg;
  logic [2:0]    hsize;
  logic [31:0]   hwdata, hrdata, seed;
  logic          strap, aux_audio_wr, aux_audio_wr_val;
  logic          master_low_start, slave_setup_start;
  logic          scl_drive_low, slave_setup_busy, slave_setup_done;
  logic          data_island_mode, repeater_mode;
  logic          inband_i2s_valid, inband_i2s_surround;
  logic          bist_active, bist_start, err_count_clear;
  logic          second_port_select, irq;
  scs_crc_ev_t   crc_err;
  scs_path_cfg_t path_cfg;
  int            mismatches, checks;

  // single slave: its ready out is the bus ready
  scs_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .mode_strap_pin_zero(strap),
    .aux_audio_wr(aux_audio_wr), .aux_audio_wr_val(aux_audio_wr_val),
    .master_low_start(master_low_start),
    .slave_setup_start(slave_setup_start), .scl_drive_low(scl_drive_low),
    .slave_setup_busy(slave_setup_busy),
    .slave_setup_done(slave_setup_done), .i2s_chan_cfg(i2s_chan_cfg),
    .data_island_mode(data_island_mode), .repeater_mode(repeater_mode),
    .inband_i2s_valid(inband_i2s_valid),
    .inband_i2s_surround(inband_i2s_surround), .path_cfg(path_cfg),
    .bist_active(bist_active), .bist_start(bist_start),
    .err_count_clear(err_count_clear), .crc_err(crc_err),
    .second_port_select(second_port_select), .irq(irq));

  //////////////////////////////////////////////////////////////////////////
  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected settings toward the serializer core
  function automatic scs_path_cfg_t exp_cfg(input logic [31:0] r);
    scs_path_cfg_t c;
    logic          eff;
    eff = (r[10] & r[11]) ? r[12] : r[0];
    c.wide_payload_select = r[1];
    c.surround_active     = eff & r[9];
    c.aux_audio_enable    = r[8];
    c.i2s_chan_cfg        = c.surround_active ? 2'h0 : r[14:13];
    return c;
  endfunction

  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one single ahb-lite transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd);
    // no wait-state count is assumed; only the watchdog ends a hang
    hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= {idx, 2'h0};
    hwrite <= w; hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [31:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // irq is combinational: look at it mid-cycle, off the edge
  task automatic irq_chk(input logic e);
    @(negedge ref_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge ref_clk);
  endtask

  // pulse a start and count the busy cycles that follow
  task automatic timer(input logic sl, output int len, output int dn);
    int n;
    if (sl) slave_setup_start <= 1'b1;
    else master_low_start <= 1'b1;
    @(posedge ref_clk);
    slave_setup_start <= 1'b0;
    master_low_start <= 1'b0;
    len = 0; dn = 0; n = 0;
    do begin
      @(posedge ref_clk); n++;
      if ((sl ? slave_setup_busy : scl_drive_low) === 1'b1) len++;
      if (sl && slave_setup_done === 1'b1) dn = len;
    end while ((sl ? slave_setup_busy : scl_drive_low) === 1'b1 && n < 400);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // whole run is well under a thousand cycles
  initial begin : watchdog
    #(4000 * 100);
    mismatches++;
    summarize();
  end

  initial begin
    logic [31:0] r, wd;
    int          len, dn, c0, c1;
    seed = 32'h17d2ca22; mismatches = 0; checks = 0;
    rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; aux_audio_wr = 1'b0;
    aux_audio_wr_val = 1'b0; master_low_start = 1'b0;
    slave_setup_start = 1'b0; i2s_chan_cfg = 2'h0; data_island_mode = 1'b0;
    repeater_mode = 1'b0; inband_i2s_valid = 1'b0;
    inband_i2s_surround = 1'b0; bist_active = 1'b0; bist_start = 1'b0;
    err_count_clear = 1'b0; crc_err = '0; second_port_select = 1'b0;
    strap = rnd() >> 31;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, strap capture, unmapped place
    rd_chk("low_rst", IDX_LOW, 32'h7f);
    rd_chk("path_rst", IDX_PATH, {28'h0, strap, 3'h1});
    rd_chk("err_rst", IDX_ERR, 32'h0);
    rd_chk("stat_rst", IDX_IRQ_STAT, 32'h0);
    rd_chk("unmapped", 8'h30, 32'h0);
    // default low period, then a random field
    timer(1'b0, len, dn);
    chk("low_dflt", 32'h7f + 32'h5, 32'(len));
    chk("low_min", 32'h1, {31'h0, real'(len) * STEP_MIN_NS >= LOW_MIN_NS});
    r = rnd();
    bus(1'b1, IDX_LOW, r, wd);
    rd_chk("low_rw", IDX_LOW, {24'h0, r[7:0]});
    bus(1'b1, IDX_LOW, {27'h0, r[12:8]}, wd);
    timer(1'b0, len, dn);
    chk("low_len", {27'h0, r[12:8]} + 32'h5, 32'(len));
    master_low_start <= 1'b1;                             // both at once
    timer(1'b1, len, dn);
    chk("setup_len", {27'h0, r[12:8]} + 32'h5, 32'(len));
    chk("setup_done", 32'(len), 32'(dn));
    // data path register and its settings, first two cases by hand
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      if (i == 0) begin r[12:9] = 4'b0111; r[0] = 1'b1; end
      if (i == 1) begin r[12:9] = 4'b1111; r[0] = 1'b0; end
      aux_audio_wr <= 1'b1; aux_audio_wr_val <= r[8];
      data_island_mode <= r[9]; repeater_mode <= r[10];
      inband_i2s_valid <= r[11]; inband_i2s_surround <= r[12];
      i2s_chan_cfg <= r[14:13];
      @(posedge ref_clk);
      aux_audio_wr <= 1'b0;
      bus(1'b1, IDX_PATH, r, wd);
      rd_chk("path", IDX_PATH, {28'h0, r[8], 1'b0, r[1:0]});
      chk("path_cfg", 32'(exp_cfg(r)), 32'(path_cfg));
    end
    // random errors, some outside self-test; irq masked meanwhile
    c0 = 0; c1 = 0;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      if (i < 2) r[4:0] = 5'h1f;
      bist_active <= (r[2:0] != 3'h0); crc_err <= r[4:3];
      @(posedge ref_clk);
      if (r[2:0] != 3'h0 && r[3]) c0++;
      if (r[2:0] != 3'h0 && r[4]) c1++;
    end
    crc_err <= '0;
    irq_chk(1'b0);
    rd_chk("err_p0", IDX_ERR, 32'(c0));
    second_port_select <= 1'b1;
    rd_chk("err_p1", IDX_ERR, 32'(c1));
    rd_chk("stat_ev", IDX_IRQ_STAT, 32'hb);
    bus(1'b1, IDX_IRQ_EN, 32'h3, wd);
    irq_chk(1'b1);
    rd_chk("irq_en", IDX_IRQ_EN, 32'h3);
    bus(1'b1, IDX_IRQ_CLR, 32'hf, wd);
    rd_chk("stat_clr", IDX_IRQ_STAT, 32'h0);
    irq_chk(1'b0);
    // run both counters well past the top
    bist_active <= 1'b1;
    crc_err <= '1;
    repeat (300) @(posedge ref_clk);
    crc_err <= '0;
    rd_chk("err_sat1", IDX_ERR, {24'h0, ERR_SAT});
    second_port_select <= 1'b0;
    rd_chk("err_sat0", IDX_ERR, {24'h0, ERR_SAT});
    rd_chk("stat_sat", IDX_IRQ_STAT, 32'h7);
    irq_chk(1'b1);
    // external clear, then a new self-test run
    err_count_clear <= 1'b1;
    @(posedge ref_clk);
    err_count_clear <= 1'b0;
    rd_chk("err_clr", IDX_ERR, 32'h0);
    crc_err <= 2'h1;
    repeat (3) @(posedge ref_clk);
    crc_err <= '0;
    rd_chk("err_three", IDX_ERR, 32'h3);
    bist_start <= 1'b1;
    @(posedge ref_clk);
    bist_start <= 1'b0;
    rd_chk("err_start", IDX_ERR, 32'h0);
    summarize();
  end

endmodule

`default_nettype wire
